//--- rtl/pcr_pkg.sv
// Register map, field layout and bus types for the peripheral clock and reset control block.
package pcr_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Byte addresses of the registers.
  localparam logic [31:0] ACCEL_CLOCK_GATE_ADDR = 32'h3ff0001c;
  localparam logic [31:0] ACCEL_RESET_HOLD_ADDR = 32'h3ff00020;
  localparam logic [31:0] SECOND_CORE_RESET_ADDR = 32'h3ff0002c;
  localparam logic [31:0] SECOND_CORE_CLOCK_GATE_ADDR = 32'h3ff00030;
  localparam logic [31:0] SECOND_CORE_STALL_ADDR = 32'h3ff00034;
  localparam logic [31:0] SECOND_CORE_BOOT_VECTOR_ADDR = 32'h3ff00038;
  localparam logic [31:0] PERIPHERAL_CLOCK_GATE_ADDR = 32'h3ff000c0;
  localparam logic [31:0] PERIPHERAL_RESET_HOLD_ADDR = 32'h3ff000c4;
  localparam logic [31:0] RADIO_CLOCK_GATE_ADDR = 32'h3ff000cc;
  localparam logic [31:0] RADIO_RESET_HOLD_ADDR = 32'h3ff000d0;

  // Field widths and positions.
  localparam int unsigned ACCEL_N = 5;
  localparam int unsigned PERIPH_N = 27;
  localparam int unsigned ACCEL_AES_BIT = 0;
  localparam int unsigned ACCEL_SHA_BIT = 1;
  localparam int unsigned ACCEL_RSA_BIT = 2;
  localparam int unsigned ACCEL_SECURE_BOOT_BIT = 3;
  localparam int unsigned ACCEL_SIGNATURE_BIT = 4;
  localparam int unsigned SECOND_CORE_RESET_BIT_POS = 0;
  localparam int unsigned SECOND_CORE_CLOCK_ON_BIT_POS = 0;
  localparam int unsigned SECOND_CORE_STALL_BIT_POS = 0;

  // Reset values.
  localparam logic [4:0] ACCEL_CLOCK_GATE_RST = 5'h00;
  localparam logic [4:0] ACCEL_RESET_HOLD_RST = 5'h00;
  localparam logic SECOND_CORE_RESET_RST = 1'b1;
  localparam logic SECOND_CORE_CLOCK_ON_RST = 1'b0;
  localparam logic SECOND_CORE_STALL_RST = 1'b0;
  localparam logic [31:0] SECOND_CORE_BOOT_VECTOR_RST = 32'h00000000;
  localparam logic [26:0] PERIPHERAL_CLOCK_GATE_RST = 27'h0000000;
  localparam logic [26:0] PERIPHERAL_RESET_HOLD_RST = 27'h0000000;
  localparam logic [31:0] RADIO_CLOCK_GATE_RST = 32'h00000000;
  localparam logic [31:0] RADIO_RESET_HOLD_RST = 32'h00000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Controls handed to the second core.
  typedef struct packed {
    logic reset;
    logic clock_on;
    logic stall;
    logic [31:0] boot_vector;
  } pcr_core_ctrl_t;

  // Per-block clock enables and reset holds.
  typedef struct packed {
    logic [ACCEL_N-1:0] accel_clock_on;
    logic [ACCEL_N-1:0] accel_reset;
    logic [PERIPH_N-1:0] periph_clock_on;
    logic [PERIPH_N-1:0] periph_reset;
    logic [31:0] radio_clock_on;
    logic [31:0] radio_reset;
  } pcr_gate_ctrl_t;

endpackage

//--- rtl/pcr_ctrl.sv
// Peripheral clock gating and reset control block with an AXI4-Lite register slave.
//
// What this block does
// - Second core held in reset while bit set.
// - Second core clock stops when enable cleared.
// - Second core stalled while stall bit set.
// - Boot register value given as jump address.
// - Clock-gating bits active high, one enables.
// - Reset bits active high, one holds reset.
// - Reset bits never self-clear in hardware.
// - Accelerator clocks: AES, SHA, RSA, boot, signature.
// - Accelerator resets share clock bit positions.
// - Signature reset also resets AES and RSA.
// - Secure-boot reset also resets AES and SHA.
// - Peripheral clock bits 0-13 in listed order.
// - Peripheral clock bits 14-26 in listed order.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pcr_ctrl
  import pcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output pcr_core_ctrl_t core_o,
  output pcr_gate_ctrl_t gate_o
);

  // Register storage.
  logic [ACCEL_N-1:0] accel_clock_gate, next_accel_clock_gate;
  logic [ACCEL_N-1:0] accel_reset_hold, next_accel_reset_hold;
  logic [ACCEL_N-1:0] accel_reset_out, next_accel_reset_out;
  logic second_core_reset, next_second_core_reset;
  logic second_core_clock_gate, next_second_core_clock_gate;
  logic second_core_stall, next_second_core_stall;
  logic [31:0] second_core_boot_vector, next_second_core_boot_vector;
  logic [PERIPH_N-1:0] peripheral_clock_gate, next_peripheral_clock_gate;
  logic [PERIPH_N-1:0] peripheral_reset_hold, next_peripheral_reset_hold;
  logic [31:0] radio_clock_gate, next_radio_clock_gate;
  logic [31:0] radio_reset_hold, next_radio_reset_hold;

  // Write channel capture: address and data may arrive in either order.
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [31:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic do_write;
  logic wr_hit;
  logic [31:0] wmask;
  logic rd_hit;
  logic [31:0] rd_word;

  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o = !w_held && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = rdata;

  // Byte-enable mask built once per lane.
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_mask
      assign wmask[lane*8 +: 8] = {8{w_strb[lane]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    do_write = aw_held && w_held && !bvalid;
    wr_hit = 1'b0;
    case (aw_addr)
      ACCEL_CLOCK_GATE_ADDR, ACCEL_RESET_HOLD_ADDR, SECOND_CORE_RESET_ADDR,
      SECOND_CORE_CLOCK_GATE_ADDR, SECOND_CORE_STALL_ADDR, SECOND_CORE_BOOT_VECTOR_ADDR,
      PERIPHERAL_CLOCK_GATE_ADDR, PERIPHERAL_RESET_HOLD_ADDR, RADIO_CLOCK_GATE_ADDR,
      RADIO_RESET_HOLD_ADDR: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  // Write channel state. The held address and data survive until both halves
  // have arrived, which is what lets the master offer them in either order.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // Accelerator gates and resets. Reset bits change only on a software write.
  always_comb begin
    next_accel_clock_gate = accel_clock_gate;
    next_accel_reset_hold = accel_reset_hold;
    if (do_write) begin
      case (aw_addr)
        ACCEL_CLOCK_GATE_ADDR: begin
          next_accel_clock_gate = ACCEL_N'(merge(32'(accel_clock_gate), w_data, wmask));
        end
        ACCEL_RESET_HOLD_ADDR: begin
          next_accel_reset_hold = ACCEL_N'(merge(32'(accel_reset_hold), w_data, wmask));
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      accel_clock_gate <= ACCEL_CLOCK_GATE_RST;
      accel_reset_hold <= ACCEL_RESET_HOLD_RST;
    end else begin
      accel_clock_gate <= next_accel_clock_gate;
      accel_reset_hold <= next_accel_reset_hold;
    end
  end

  // Second core controls. Each one-bit field sits in byte lane 0, so a write
  // whose strobe leaves that lane out leaves the field untouched.
  always_comb begin
    next_second_core_reset = second_core_reset;
    next_second_core_clock_gate = second_core_clock_gate;
    next_second_core_stall = second_core_stall;
    next_second_core_boot_vector = second_core_boot_vector;
    if (do_write) begin
      case (aw_addr)
        SECOND_CORE_RESET_ADDR: begin
          if (w_strb[0]) begin
            next_second_core_reset = w_data[SECOND_CORE_RESET_BIT_POS];
          end
        end
        SECOND_CORE_CLOCK_GATE_ADDR: begin
          if (w_strb[0]) begin
            next_second_core_clock_gate = w_data[SECOND_CORE_CLOCK_ON_BIT_POS];
          end
        end
        SECOND_CORE_STALL_ADDR: begin
          if (w_strb[0]) begin
            next_second_core_stall = w_data[SECOND_CORE_STALL_BIT_POS];
          end
        end
        SECOND_CORE_BOOT_VECTOR_ADDR: begin
          next_second_core_boot_vector = merge(second_core_boot_vector, w_data, wmask);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      second_core_reset <= SECOND_CORE_RESET_RST;
      second_core_clock_gate <= SECOND_CORE_CLOCK_ON_RST;
      second_core_stall <= SECOND_CORE_STALL_RST;
      second_core_boot_vector <= SECOND_CORE_BOOT_VECTOR_RST;
    end else begin
      second_core_reset <= next_second_core_reset;
      second_core_clock_gate <= next_second_core_clock_gate;
      second_core_stall <= next_second_core_stall;
      second_core_boot_vector <= next_second_core_boot_vector;
    end
  end

  // Peripheral gates and resets. Bits above the mapped range read back as zero;
  // keeping the shared UART buffer clocked while a UART works is up to software.
  always_comb begin
    next_peripheral_clock_gate = peripheral_clock_gate;
    next_peripheral_reset_hold = peripheral_reset_hold;
    if (do_write) begin
      case (aw_addr)
        PERIPHERAL_CLOCK_GATE_ADDR: begin
          next_peripheral_clock_gate =
            PERIPH_N'(merge(32'(peripheral_clock_gate), w_data, wmask));
        end
        PERIPHERAL_RESET_HOLD_ADDR: begin
          next_peripheral_reset_hold =
            PERIPH_N'(merge(32'(peripheral_reset_hold), w_data, wmask));
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      peripheral_clock_gate <= PERIPHERAL_CLOCK_GATE_RST;
      peripheral_reset_hold <= PERIPHERAL_RESET_HOLD_RST;
    end else begin
      peripheral_clock_gate <= next_peripheral_clock_gate;
      peripheral_reset_hold <= next_peripheral_reset_hold;
    end
  end

  // Radio gates and resets. Their bit layout is not fixed here, so they are
  // kept as plain read/write words.
  always_comb begin
    next_radio_clock_gate = radio_clock_gate;
    next_radio_reset_hold = radio_reset_hold;
    if (do_write) begin
      case (aw_addr)
        RADIO_CLOCK_GATE_ADDR: begin
          next_radio_clock_gate = merge(radio_clock_gate, w_data, wmask);
        end
        RADIO_RESET_HOLD_ADDR: begin
          next_radio_reset_hold = merge(radio_reset_hold, w_data, wmask);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      radio_clock_gate <= RADIO_CLOCK_GATE_RST;
      radio_reset_hold <= RADIO_RESET_HOLD_RST;
    end else begin
      radio_clock_gate <= next_radio_clock_gate;
      radio_reset_hold <= next_radio_reset_hold;
    end
  end

  // Read path: one outstanding read, answer one cycle after the address is taken.
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr_i)
      ACCEL_CLOCK_GATE_ADDR: rd_word = 32'(accel_clock_gate);
      ACCEL_RESET_HOLD_ADDR: rd_word = 32'(accel_reset_hold);
      SECOND_CORE_RESET_ADDR: rd_word = 32'(second_core_reset);
      SECOND_CORE_CLOCK_GATE_ADDR: rd_word = 32'(second_core_clock_gate);
      SECOND_CORE_STALL_ADDR: rd_word = 32'(second_core_stall);
      SECOND_CORE_BOOT_VECTOR_ADDR: rd_word = second_core_boot_vector;
      PERIPHERAL_CLOCK_GATE_ADDR: rd_word = 32'(peripheral_clock_gate);
      PERIPHERAL_RESET_HOLD_ADDR: rd_word = 32'(peripheral_reset_hold);
      RADIO_CLOCK_GATE_ADDR: rd_word = radio_clock_gate;
      RADIO_RESET_HOLD_ADDR: rd_word = radio_reset_hold;
      default: rd_hit = 1'b0;
    endcase
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      next_rdata = rd_word;
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // Read channel state. The answer is captured when the address is taken, so a
  // write landing meanwhile cannot change data already on its way back.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Outputs straight from the control flip-flops, both clock and reset active high.
  assign core_o.reset = second_core_reset;
  assign core_o.clock_on = second_core_clock_gate;
  assign core_o.stall = second_core_stall;
  assign core_o.boot_vector = second_core_boot_vector;
  assign gate_o.accel_clock_on = accel_clock_gate;
  assign gate_o.periph_clock_on = peripheral_clock_gate;
  assign gate_o.periph_reset = peripheral_reset_hold;
  assign gate_o.radio_clock_on = radio_clock_gate;
  assign gate_o.radio_reset = radio_reset_hold;

  // The combined engines share state with AES, SHA and RSA, so their resets spread.
  // Reading back the register still shows only what software wrote. The spread is
  // built from the next value so that it lands on the same edge as the write.
  always_comb begin
    next_accel_reset_out = next_accel_reset_hold;
    if (next_accel_reset_hold[ACCEL_SIGNATURE_BIT]) begin
      next_accel_reset_out[ACCEL_AES_BIT] = 1'b1;
      next_accel_reset_out[ACCEL_RSA_BIT] = 1'b1;
    end
    if (next_accel_reset_hold[ACCEL_SECURE_BOOT_BIT]) begin
      next_accel_reset_out[ACCEL_AES_BIT] = 1'b1;
      next_accel_reset_out[ACCEL_SHA_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      accel_reset_out <= ACCEL_RESET_HOLD_RST;
    end else begin
      accel_reset_out <= next_accel_reset_out;
    end
  end

  assign gate_o.accel_reset = accel_reset_out;

endmodule

`default_nettype wire

//--- tb/pcr_core_model.sv
// Behavioural second core whose fetch address follows its control inputs.
`timescale 1ns/1ps
`default_nettype none
module pcr_core_model
  import pcr_pkg::*;
(
  input wire logic clk_i,
  input wire pcr_core_ctrl_t core_i,
  output logic [31:0] pc_o
);
  // The fetch address loads the boot vector while in reset, and only advances while the core is out of reset, clocked and not stalled.
  always @(posedge clk_i) begin
    if (core_i.reset) pc_o <= core_i.boot_vector;
    else if (core_i.clock_on && !core_i.stall) pc_o <= pc_o + 32'h4;
  end
endmodule
`default_nettype wire

//--- tb/pcr_ctrl_checker.sv
// Concurrent checks on the ports of the clock and reset control block.
`timescale 1ns/1ps
`default_nettype none
module pcr_ctrl_checker
  import pcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire pcr_core_ctrl_t core_o,
  input wire pcr_gate_ctrl_t gate_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer missing");
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write answer dropped");
  wr_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("address taken during response");
  ar_block_a: assert property (s_axi_arready_o != s_axi_rvalid_o)
    else $error("read ready wrong");
  sig_cascade_a: assert property (gate_o.accel_reset[4] |->
    gate_o.accel_reset[0] && gate_o.accel_reset[2])
    else $error("signature reset cascade missing");
  boot_cascade_a: assert property (gate_o.accel_reset[3] |->
    gate_o.accel_reset[0] && gate_o.accel_reset[1])
    else $error("secure boot reset cascade missing");
  rst_keep_a: assert property (!$rose(s_axi_bvalid_o) |->
    $stable(gate_o.periph_reset) && $stable(core_o.reset) && $stable(gate_o.accel_reset))
    else $error("reset bit changed without write");
  core_init_a: assert property ($fell(reset_i) |->
    core_o.reset && !core_o.clock_on && !core_o.stall)
    else $error("second core not held after reset");
endmodule
bind pcr_ctrl pcr_ctrl_checker u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .core_o(core_o), .gate_o(gate_o));
`default_nettype wire

//--- tb/test_periph_clock_reset_ctrl.sv
// Self-checking bench for the clock and reset control block over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module test_periph_clock_reset_ctrl;
  import pcr_pkg::*;
  typedef struct packed {logic [31:0] d; logic [1:0] r;} pcr_note_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, pc, v, boot;
  pcr_core_ctrl_t core;
  pcr_gate_ctrl_t gate;
  pcr_note_t q[$];
  logic [1:0] bq[$];
  logic [3:0] wstrb = 4'hf;
  pcr_note_t n;
  int err_total = 0, compares = 0, seed = 32'hd1c7;
  logic [31:0] ra [10] = '{ACCEL_CLOCK_GATE_ADDR, ACCEL_RESET_HOLD_ADDR, SECOND_CORE_RESET_ADDR,
    SECOND_CORE_CLOCK_GATE_ADDR, SECOND_CORE_STALL_ADDR, SECOND_CORE_BOOT_VECTOR_ADDR,
    PERIPHERAL_CLOCK_GATE_ADDR, PERIPHERAL_RESET_HOLD_ADDR, RADIO_CLOCK_GATE_ADDR,
    RADIO_RESET_HOLD_ADDR};
  logic [31:0] rm [10] = '{32'h1f, 32'h1f, 32'h1, 32'h1, 32'h1, 32'hffffffff, 32'h7ffffff,
    32'h7ffffff, 32'hffffffff, 32'hffffffff};
  initial forever #25 clk_i = ~clk_i;
  pcr_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .core_o(core), .gate_o(gate));
  pcr_core_model u_core (.clk_i(clk_i), .core_i(core), .pc_o(pc));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_resp(input string s, input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(e);
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    q.push_back('{e, r});
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // Accelerator reset as the gated blocks see it, with the two cascades folded in.
  function automatic logic [4:0] fx(input logic [4:0] x);
    return x | (x[4] ? 5'h05 : 5'h00) | (x[3] ? 5'h03 : 5'h00);
  endfunction
  always @(posedge clk_i) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk_resp("bresp", bq.pop_front(), bresp);
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      n = q.pop_front();
      chk("rdata", n.d, rdata);
      chk_resp("rresp", n.r, rresp);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    $display("timeout");
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 10; i++) rd(ra[i], (i == 2) ? 32'h1 : 32'h0, RESP_OKAY);
    $display("done reset values");
    for (int i = 0; i < 10; i++) begin
      v = $random(seed) | ((i == 6) ? 32'h01000000 : 32'h0);
      wr(ra[i], v, RESP_OKAY);
      rd(ra[i], v & rm[i], RESP_OKAY);
    end
    wr(32'h3ff00024, v, RESP_SLVERR);
    rd(32'h3ff00024, 32'h0, RESP_SLVERR);
    wr(RADIO_CLOCK_GATE_ADDR, v, RESP_OKAY);
    wr(RADIO_RESET_HOLD_ADDR, ~v, RESP_OKAY);
    chk("radio clock", v, gate.radio_clock_on);
    chk("radio reset", ~v, gate.radio_reset);
    $display("done read write map");
    for (int k = 0; k < 27; k++) begin
      v = (32'h1 << k) | 32'h01000000;
      wr(PERIPHERAL_CLOCK_GATE_ADDR, v, RESP_OKAY);
      wr(PERIPHERAL_RESET_HOLD_ADDR, v, RESP_OKAY);
      chk("periph clock", v, {5'h0, gate.periph_clock_on});
      chk("periph reset", v, {5'h0, gate.periph_reset});
    end
    for (int k = 0; k < 5; k++) begin
      v = 32'h1 << k;
      wr(ACCEL_CLOCK_GATE_ADDR, v, RESP_OKAY);
      wr(ACCEL_RESET_HOLD_ADDR, v, RESP_OKAY);
      chk("accel clock", v, {27'h0, gate.accel_clock_on});
      chk("accel reset", {27'h0, fx(v[4:0])}, {27'h0, gate.accel_reset});
      rd(ACCEL_RESET_HOLD_ADDR, v, RESP_OKAY);
    end
    repeat (20) @(posedge clk_i);
    chk("reset kept", 32'h05000000, {5'h0, gate.periph_reset});
    $display("done gating map");
    boot = $random(seed);
    wr(SECOND_CORE_RESET_ADDR, 32'h1, RESP_OKAY);
    wr(SECOND_CORE_STALL_ADDR, 32'h0, RESP_OKAY);
    wr(SECOND_CORE_CLOCK_GATE_ADDR, 32'h0, RESP_OKAY);
    wr(SECOND_CORE_BOOT_VECTOR_ADDR, boot, RESP_OKAY);
    wr(SECOND_CORE_RESET_ADDR, 32'h0, RESP_OKAY);
    chk("boot vector", boot, core.boot_vector);
    chk("core clock", 32'h0, {31'h0, core.clock_on});
    repeat (4) @(posedge clk_i);
    chk("pc gated", boot, pc);
    wr(SECOND_CORE_STALL_ADDR, 32'h1, RESP_OKAY);
    wr(SECOND_CORE_CLOCK_GATE_ADDR, 32'h1, RESP_OKAY);
    chk("core stall", 32'h1, {31'h0, core.stall});
    repeat (4) @(posedge clk_i);
    chk("pc stalled", boot, pc);
    wr(SECOND_CORE_STALL_ADDR, 32'h0, RESP_OKAY);
    repeat (4) @(posedge clk_i);
    chk("pc runs", 32'h1, {31'h0, pc !== boot});
    wr(SECOND_CORE_RESET_ADDR, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk_i);
    chk("core reset", 32'h1, {31'h0, core.reset});
    chk("pc reset", boot, pc);
    wstrb <= 4'h3;
    wr(SECOND_CORE_BOOT_VECTOR_ADDR, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    chk("boot lanes", {boot[31:16], 16'h0}, core.boot_vector);
    $display("done second core");
    finish_test;
  end
endmodule
`default_nettype wire
